/* File: test/wpf_far_model.sv */
// Stand-in for the timer and the I/O port around the block
`timescale 1ns/1ps
`default_nettype none
module wpf_far_model (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       upd_en,
   input  wire logic [7:0] dir_sw,
   input  wire logic [7:0] dir_clear,
   input  wire logic [7:0] dir_restore,
   output logic [3:0]      tc_waveform,
   output logic            tc_update,
   output logic [7:0]      port_dir
);
   logic [7:0] cnt_r = 8'h00;
   always @(posedge aclk) begin
      if (!aresetn)
         cnt_r <= 8'h00;
      else
         cnt_r <= cnt_r + 8'h01;
   end
   // Uneven bit picks so every channel is seen in both states
   assign tc_waveform = {cnt_r[5], cnt_r[2], cnt_r[4], cnt_r[1]};
   // One-cycle UPDATE every 16 clocks, held off so the bench decides when buffers load
   assign tc_update = upd_en && (cnt_r[3:0] == 4'hf);
   // Software direction is set at reset; a fault clears pins and the exit restores them
   always @(posedge aclk) begin
      if (!aresetn)
         port_dir <= dir_sw;
      else
         port_dir <= (port_dir & ~dir_clear) | (dir_restore & dir_sw);
   end
endmodule
`default_nettype wire

/* File: test/wpf_top_tb.sv */
// Self-checking bench for the pattern and fault protect block
`timescale 1ns/1ps
`default_nettype none
module wpf_top_tb;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00, fault_evt = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        dbg_break = 1'b0, ext_lock = 1'b0, upd_en = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, tc_update, fault_state, tc_err_set;
   logic [1:0]  bresp, rresp, rs;
   logic [3:0]  tc_waveform, wg_q;
   logic [7:0]  pin_out, pin_ovr_en, dir_clear, dir_restore, port_dir, v, cv, m;
   logic [2:0]  k;
   logic [7:0]  ctl [2] = '{8'h0f, 8'h15};
   int          n_errors = 0, check_count = 0, seed = 32'h1da6cb74;

   wpf_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .tc_waveform(tc_waveform), .tc_update(tc_update), .fault_evt(fault_evt),
      .dbg_break(dbg_break), .ext_lock(ext_lock), .pin_out(pin_out), .pin_ovr_en(pin_ovr_en),
      .dir_clear(dir_clear), .dir_restore(dir_restore), .tc_err_set(tc_err_set),
      .fault_state(fault_state));
   wpf_far_model far (.aclk(aclk), .aresetn(aresetn), .upd_en(upd_en), .dir_sw(8'hff),
      .dir_clear(dir_clear), .dir_restore(dir_restore), .tc_waveform(tc_waveform),
      .tc_update(tc_update), .port_dir(port_dir));

   initial begin
      forever #5 aclk = ~aclk;
   end
   // Waveform level that the block sampled at the latest edge
   always @(posedge aclk) wg_q <= tc_waveform;

   function automatic logic [7:0] exp_pins(input logic [7:0] c, input logic [3:0] w);
      for (int i = 0; i < 4; i++) begin
         exp_pins[2*i] = c[4] ? w[0] : w[i];
         exp_pins[2*i+1] = ~exp_pins[2*i];
      end
   endfunction
   function automatic logic [7:0] cpins(input logic [3:0] e);
      for (int i = 0; i < 8; i++) cpins[i] = e[i/2];
   endfunction

   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (e !== g) begin
         $display("unexpected %s: expected %h seen %h", nm, e, g);
         n_errors++;
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge aclk);
      awaddr <= {a, 2'b00};
      wdata <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && n < 50);
      if (bvalid !== 1'b1) n_errors++;
      bready <= 1'b0;
      r = bresp;
   endtask
   task automatic rd(input logic [5:0] a, output logic [7:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge aclk);
      araddr <= {a, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (arready)
            arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && n < 50);
      if (rvalid !== 1'b1) n_errors++;
      rready <= 1'b0;
      d = rdata[7:0];
      r = rresp;
   endtask
   task automatic rdc(input logic [5:0] a, input logic [7:0] e, input string nm);
      logic [7:0] d;
      logic [1:0] r;
      rd(a, d, r);
      chk(nm, e, d);
   endtask
   // Called at a falling edge; the exit must land on an edge that saw UPDATE
   task automatic wait_clear();
      logic u;
      int n;
      u = 1'b1;
      n = 0;
      while (fault_state !== 1'b0 && n < 200) begin
         u = tc_update;
         @(negedge aclk);
         n++;
      end
      chk("exit_on_update", 8'h01, {7'h00, u});
      chk("fault_exit", 8'h00, {7'h00, fault_state});
   endtask
   task automatic summarize();
      if (n_errors == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge aclk);
      n_errors++;
      summarize();
   end

   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      rdc(wpf_pkg::IDX_CTRL, 8'h00, "ctrl_reset");
      rdc(wpf_pkg::IDX_FDMASK, 8'h00, "mask_reset");
      for (int i = 0; i < 4; i++) begin
         cv = 8'($random(seed));
         wr(wpf_pkg::IDX_CTRL, cv, rs);
         cv = cv & 8'h3f;
         rdc(wpf_pkg::IDX_CTRL, cv, "ctrl_rw");
      end
      rd(6'h05, v, rs);
      chk("rresp", {6'h00, wpf_pkg::RESP_SLVERR}, {6'h00, rs});
      wr(6'h06, 8'h5a, rs);
      chk("bresp", {6'h00, wpf_pkg::RESP_SLVERR}, {6'h00, rs});
      ext_lock <= 1'b1;
      wr(wpf_pkg::IDX_CTRL, cv ^ 8'h15, rs);
      wr(wpf_pkg::IDX_FDMASK, 8'h3c, rs);
      wr(wpf_pkg::IDX_OVREN, 8'h3c, rs);
      rdc(wpf_pkg::IDX_CTRL, cv, "ctrl_locked");
      rdc(wpf_pkg::IDX_FDMASK, 8'h00, "mask_locked");
      rdc(wpf_pkg::IDX_OVREN, 8'h00, "ovr_locked");
      ext_lock <= 1'b0;
      wr(wpf_pkg::IDX_OVREN, 8'hff, rs);
      foreach (ctl[j]) begin
         wr(wpf_pkg::IDX_CTRL, ctl[j], rs);
         m = cpins(ctl[j][3:0]);
         repeat (6) begin
            @(negedge aclk);
            chk("pin_out", exp_pins(ctl[j], wg_q) & m, pin_out & m);
            chk("pin_ovr_en", m, pin_ovr_en);
         end
      end
      v = 8'($random(seed));
      wr(wpf_pkg::IDX_CTRL, 8'h20, rs);
      wr(wpf_pkg::IDX_DTLS, v, rs);
      wr(wpf_pkg::IDX_OVREN, 8'h0f, rs);
      repeat (6) begin
         @(negedge aclk);
         chk("pattern", {v[7:4], {4{wg_q[0]}}}, pin_out);
         chk("pattern_ovr", 8'hff, pin_ovr_en);
      end
      wr(wpf_pkg::IDX_DTLSBUF, ~v, rs);
      wr(wpf_pkg::IDX_DTHSBUF, 8'hf0, rs);
      repeat (20) @(negedge aclk);
      chk("pattern_hold", {4'h0, v[7:4]}, {4'h0, pin_out[7:4]});
      @(posedge aclk);
      upd_en <= 1'b1;
      for (int n = 0; n < 40 && tc_update !== 1'b1; n++) @(posedge aclk);
      upd_en <= 1'b0;
      @(posedge aclk);
      @(negedge aclk);
      chk("pattern_upd", {{4{wg_q[0]}}, ~v[3:0]}, pin_out);
      wr(wpf_pkg::IDX_CTRL, 8'h05, rs);
      k = 3'($random(seed));
      m = 8'h01 << k;
      wr(wpf_pkg::IDX_FDMASK, m, rs);
      for (int a = 0; a < 4; a++) begin
         wr(wpf_pkg::IDX_FDCTRL, {5'h01, 1'b1, 2'(a)}, rs);
         fault_evt <= ~m;
         @(negedge aclk);
         chk("masked_evt", 8'h00, {7'h00, tc_err_set});
         @(posedge aclk);
         fault_evt <= m;
         @(negedge aclk);
         chk("err_set", {7'h00, a != 0}, {7'h00, tc_err_set});
         chk("dir_clear", (a == 3) ? 8'h33 : 8'h00, dir_clear);
         @(posedge aclk);
         fault_evt <= 8'h00;
         @(negedge aclk);
         chk("fault_state", {7'h00, a != 0}, {7'h00, fault_state});
         if (a == 3) begin
            chk("port_dir", 8'hcc, port_dir);
            rdc(wpf_pkg::IDX_STATUS, 8'h04, "fault_flag_set");
            @(negedge aclk);
            chk("pin_blank", 8'h00, pin_out);
            wr(wpf_pkg::IDX_STATUS, 8'h04, rs);
            rdc(wpf_pkg::IDX_STATUS, 8'h00, "fault_flag_clr");
            wr(wpf_pkg::IDX_OVREN, 8'haa, rs);
            rdc(wpf_pkg::IDX_OVREN, 8'hf0, "ovr_blocked");
         end
         @(posedge aclk);
         upd_en <= 1'b1;
         @(negedge aclk);
         wait_clear();
         @(negedge aclk);
         chk("dir_restore", (a == 3) ? 8'h33 : 8'h00, dir_restore);
         @(posedge aclk);
         upd_en <= 1'b0;
         @(negedge aclk);
         chk("port_dir_back", 8'hff, port_dir);
      end
      wr(wpf_pkg::IDX_FDCTRL, 8'h03, rs);
      dbg_break <= 1'b1;
      repeat (3) @(posedge aclk);
      dbg_break <= 1'b0;
      upd_en <= 1'b1;
      repeat (40) @(negedge aclk);
      chk("latched_hold", 8'h01, {7'h00, fault_state});
      wr(wpf_pkg::IDX_STATUS, 8'h04, rs);
      @(negedge aclk);
      wait_clear();
      wr(wpf_pkg::IDX_FDCTRL, 8'h13, rs);
      dbg_break <= 1'b1;
      @(negedge aclk);
      chk("break_ignored", 8'h00, {7'h00, tc_err_set});
      @(posedge aclk);
      dbg_break <= 1'b0;
      @(negedge aclk);
      chk("break_no_fault", 8'h00, {7'h00, fault_state});
      summarize();
   end
endmodule
`default_nettype wire

/* File: verilog/wpf_fault_unit.sv */
// Fault detection and restore state machine
`timescale 1ns/1ps
`default_nettype none
module wpf_fault_unit (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic [7:0] fault_evt,
   input  wire logic [7:0] evt_mask,
   input  wire logic [1:0] fault_act,
   input  wire logic       restore_cbc,
   input  wire logic       dbg_fault_dis,
   input  wire logic       dbg_break,
   input  wire logic       tc_update,
   input  wire logic       fflag_clr,
   output logic            fault_cond,
   output logic            fault_active,
   output logic            fflag
);
   wpf_pkg::wpf_fstate_t state_r, state_nxt;
   logic fflag_r;
   logic prot_on;

   // Runs with no processor help, from the peripheral clock alone
   assign prot_on = (fault_act != wpf_pkg::ACT_NONE); // RL22 RL9
   assign fault_cond = prot_on & ((|(fault_evt & evt_mask)) // RL5
                      | (dbg_break & ~dbg_fault_dis)); // RL16 RL25
   assign fault_active = (state_r != wpf_pkg::FS_NORMAL);
   assign fflag = fflag_r;

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         wpf_pkg::FS_NORMAL: begin
            if (fault_cond) state_nxt = wpf_pkg::FS_FAULT;
         end
         wpf_pkg::FS_FAULT: begin
            // Latched mode also waits for software to clear the flag
            if (!fault_cond && (restore_cbc || !fflag_r)) // RL10 RL11 RL17
               state_nxt = wpf_pkg::FS_WAIT;
         end
         wpf_pkg::FS_WAIT: begin
            if (fault_cond) state_nxt = wpf_pkg::FS_FAULT;
            else if (!restore_cbc && fflag_r) state_nxt = wpf_pkg::FS_FAULT;
            else if (tc_update) state_nxt = wpf_pkg::FS_NORMAL; // RL14
         end
         default: state_nxt = wpf_pkg::FS_FAULT;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) state_r <= wpf_pkg::FS_NORMAL;
      else state_r <= state_nxt;
   end

   // A new fault in the clearing cycle keeps the flag set
   always_ff @(posedge aclk) begin
      if (!aresetn) fflag_r <= 1'b0;
      else if (fault_cond) fflag_r <= 1'b1; // RL7
      else if (fflag_clr) fflag_r <= 1'b0; // RL24
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_fault_enters: assert property (fault_cond |=> fault_active && fflag) // RL7
      else $error("fault not entered");
   a_latched_hold: assert property (fault_active && !restore_cbc && fflag |=> fault_active) // RL10
      else $error("latched fault released with flag set");
   a_update_exit: assert property (state_r == wpf_pkg::FS_WAIT && tc_update && !fault_cond
      && (restore_cbc || !fflag_r) |=> !fault_active) // RL11
      else $error("fault not left at update");
   a_no_early_exit: assert property (fault_active && !tc_update |=> fault_active) // RL14
      else $error("fault left without update");
endmodule
`default_nettype wire

/* File: verilog/wpf_pkg.sv */
// Constants, register map and helpers for the waveform pattern and fault protect block
package wpf_pkg;
   // Printed offsets are register indices; byte address is four times the index
   localparam logic [5:0] IDX_CTRL    = 6'h00;
   localparam logic [5:0] IDX_FDMASK  = 6'h02;
   localparam logic [5:0] IDX_FDCTRL  = 6'h03;
   localparam logic [5:0] IDX_STATUS  = 6'h04;
   localparam logic [5:0] IDX_DTLS    = 6'h08;
   localparam logic [5:0] IDX_DTHS    = 6'h09;
   localparam logic [5:0] IDX_DTLSBUF = 6'h0a;
   localparam logic [5:0] IDX_DTHSBUF = 6'h0b;
   localparam logic [5:0] IDX_OVREN   = 6'h0c;

   localparam int CTRL_PAT_BIT   = 5;
   localparam int CTRL_COMW_BIT  = 4;
   localparam logic [7:0] CTRL_WMASK = 8'h3f;
   localparam int FD_DBD_BIT     = 4;
   localparam int FD_MODE_BIT    = 2;
   localparam logic [7:0] FDCTRL_WMASK = 8'h17;
   localparam int ST_FFLAG_BIT   = 2;
   localparam int ST_HSV_BIT     = 1;
   localparam int ST_LSV_BIT     = 0;

   localparam logic [7:0] RST_BYTE = 8'h00;

   localparam logic [1:0] ACT_NONE     = 2'b00;
   localparam logic [1:0] ACT_CLEARDIR = 2'b11;

   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [1:0] {
      FS_NORMAL = 2'b00,
      FS_FAULT  = 2'b01,
      FS_WAIT   = 2'b11
   } wpf_fstate_t;

   // Each dead-time channel owns one pin pair: low side even, high side odd
   function automatic logic [7:0] chan_pins(input logic [3:0] en);
      chan_pins = {en[3], en[3], en[2], en[2], en[1], en[1], en[0], en[0]};
   endfunction
endpackage

/* File: verilog/wpf_top.sv */
// Waveform pattern generation and fault protection with AXI4-Lite registers
//
// What this block does
// (RL1) Pattern mode drives the dead-time registers as a synchronous pin pattern.
// (RL2) In pattern mode, pins with override enable set carry the channel A waveform.
// (RL3) Buffered pattern contents take effect only at the timer UPDATE.
// (RL4) Software must set pin directions as outputs to see the pattern.
// (RL5) Eight-bit mask enables event channels; enabled events are ORed into a fault.
// (RL6) A fault with clear action clears direction bits of enabled channels.
// (RL7) A fault sets the fault flag and the timer error flag.
// (RL8) Fault action starts within two clock cycles of the event.
// (RL9) Fault protection needs no processor, only the running clock.
// (RL10) Latched mode holds fault until condition gone and flag cleared, then UPDATE.
// (RL11) Cycle mode holds fault while condition lasts, resumes at next UPDATE.
// (RL12) Leaving the fault restores direction bits of enabled channels.
// (RL13) Fault leaves override enables intact but blocks software writes to them.
// (RL14) Fault exit uses the same UPDATE as the timer.
// (RL15) Lock blocks writes to control, override enable and event mask.
// (RL16) Debug break counts as a fault source when enabled.
// (RL17) After break, cycle mode restarts at UPDATE; latched needs flag clear.
// (RL18) Control bit 5 selects pattern mode over dead-time insertion.
// (RL19) Control bit 4 feeds channel A waveform to all four generators.
// (RL20) Control bits 3 to 0 enable each channel's dead-time generator.
// (RL21) Software writes zero to reserved control bits 7 and 6.
// (RL22) Action code 00 disables protection, 11 clears directions.
// (RL23) Fault control bit 2 picks latched (0) or cycle-by-cycle (1).
// (RL24) Writing one to status bit 2 clears the fault flag.
// (RL25) Fault control bit 4 set stops debug break from causing a fault.
`timescale 1ns/1ps
`default_nettype none
module wpf_top (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic [7:0] s_axi_awaddr,
   input  wire logic       s_axi_awvalid,
   output logic            s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0] s_axi_wstrb,
   input  wire logic       s_axi_wvalid,
   output logic            s_axi_wready,
   output logic [1:0]      s_axi_bresp,
   output logic            s_axi_bvalid,
   input  wire logic       s_axi_bready,
   input  wire logic [7:0] s_axi_araddr,
   input  wire logic       s_axi_arvalid,
   output logic            s_axi_arready,
   output logic [31:0]     s_axi_rdata,
   output logic [1:0]      s_axi_rresp,
   output logic            s_axi_rvalid,
   input  wire logic       s_axi_rready,
   input  wire logic [3:0] tc_waveform,
   input  wire logic       tc_update,
   input  wire logic [7:0] fault_evt,
   input  wire logic       dbg_break,
   input  wire logic       ext_lock,
   output logic [7:0]      pin_out,
   output logic [7:0]      pin_ovr_en,
   output logic [7:0]      dir_clear,
   output logic [7:0]      dir_restore,
   output logic            tc_err_set,
   output logic            fault_state
);
   logic       aw_hold_r, w_hold_r, wstrb0_r;
   logic [5:0] aw_idx_r;
   logic [7:0] wdata_r;
   logic       bvalid_r, rvalid_r;
   logic [1:0] bresp_r, rresp_r;
   logic [31:0] rdata_r;
   logic       wr_go, rd_go, wr_hit, rd_hit;
   logic [5:0] rd_idx;

   logic [5:0] ctrl_r;
   logic [7:0] fdmask_r, fdctrl_r, ovren_r;
   logic [7:0] dtls_r, dths_r, dtlsbuf_r, dthsbuf_r;
   logic       lsv_r, hsv_r;
   logic [7:0] pin_out_r, pin_ovr_r, dir_restore_r;
   logic       fault_prev_r;

   logic       fault_cond, fault_active, fflag, fflag_clr;
   logic [7:0] chan_mask, rd_val, pin_out_nxt, pin_ovr_nxt;
   logic [3:0] wave;
   logic       patm, comw, act_clr;

   function automatic logic wr_to(input logic [5:0] idx, input logic go,
                                  input logic [5:0] aidx, input logic s0);
      wr_to = go && s0 && (aidx == idx);
   endfunction

   function automatic logic idx_valid(input logic [5:0] idx);
      idx_valid = (idx == wpf_pkg::IDX_CTRL) || (idx == wpf_pkg::IDX_FDMASK)
         || (idx == wpf_pkg::IDX_FDCTRL) || (idx == wpf_pkg::IDX_STATUS)
         || (idx == wpf_pkg::IDX_DTLS) || (idx == wpf_pkg::IDX_DTHS)
         || (idx == wpf_pkg::IDX_DTLSBUF) || (idx == wpf_pkg::IDX_DTHSBUF)
         || (idx == wpf_pkg::IDX_OVREN);
   endfunction

   // AXI4-Lite write path: address and data taken in either order
   assign s_axi_awready = !aw_hold_r && !bvalid_r;
   assign s_axi_wready  = !w_hold_r && !bvalid_r;
   assign wr_go  = aw_hold_r && w_hold_r && !bvalid_r;
   assign wr_hit = idx_valid(aw_idx_r);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_r <= 1'b0;
         aw_idx_r  <= 6'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_hold_r <= 1'b1;
         aw_idx_r  <= s_axi_awaddr[7:2];
      end else if (wr_go) begin
         aw_hold_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_hold_r <= 1'b0;
         wdata_r  <= wpf_pkg::RST_BYTE;
         wstrb0_r <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_hold_r <= 1'b1;
         wdata_r  <= s_axi_wdata[7:0];
         wstrb0_r <= s_axi_wstrb[0];
      end else if (wr_go) begin
         w_hold_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_r <= 1'b0;
         bresp_r  <= wpf_pkg::RESP_OKAY;
      end else if (wr_go) begin
         bvalid_r <= 1'b1;
         bresp_r  <= wr_hit ? wpf_pkg::RESP_OKAY : wpf_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp  = bresp_r;

   // Read path: one read at a time, data from a register
   assign s_axi_arready = !rvalid_r;
   assign rd_go  = s_axi_arvalid && !rvalid_r;
   assign rd_idx = s_axi_araddr[7:2];
   assign rd_hit = idx_valid(rd_idx);

   always_comb begin
      rd_val = wpf_pkg::RST_BYTE;
      unique case (rd_idx)
         wpf_pkg::IDX_CTRL:    rd_val = {2'b00, ctrl_r}; // RL21
         wpf_pkg::IDX_FDMASK:  rd_val = fdmask_r;
         wpf_pkg::IDX_FDCTRL:  rd_val = fdctrl_r;
         wpf_pkg::IDX_STATUS:  rd_val = {5'h00, fflag, hsv_r, lsv_r};
         wpf_pkg::IDX_DTLS:    rd_val = dtls_r;
         wpf_pkg::IDX_DTHS:    rd_val = dths_r;
         wpf_pkg::IDX_DTLSBUF: rd_val = dtlsbuf_r;
         wpf_pkg::IDX_DTHSBUF: rd_val = dthsbuf_r;
         wpf_pkg::IDX_OVREN:   rd_val = ovren_r;
         default:              rd_val = wpf_pkg::RST_BYTE;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h0000_0000;
         rresp_r  <= wpf_pkg::RESP_OKAY;
      end else if (rd_go) begin
         rvalid_r <= 1'b1;
         rdata_r  <= {24'h00_0000, rd_val};
         rresp_r  <= rd_hit ? wpf_pkg::RESP_OKAY : wpf_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata  = rdata_r;
   assign s_axi_rresp  = rresp_r;

   // Configuration registers; lock guards control and the event mask
   always_ff @(posedge aclk) begin
      if (!aresetn) ctrl_r <= 6'h00;
      else if (wr_to(wpf_pkg::IDX_CTRL, wr_go, aw_idx_r, wstrb0_r) && !ext_lock) // RL15
         ctrl_r <= wdata_r[5:0] & wpf_pkg::CTRL_WMASK[5:0];
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) fdmask_r <= wpf_pkg::RST_BYTE;
      else if (wr_to(wpf_pkg::IDX_FDMASK, wr_go, aw_idx_r, wstrb0_r) && !ext_lock) // RL15
         fdmask_r <= wdata_r;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) fdctrl_r <= wpf_pkg::RST_BYTE;
      else if (wr_to(wpf_pkg::IDX_FDCTRL, wr_go, aw_idx_r, wstrb0_r))
         fdctrl_r <= wdata_r & wpf_pkg::FDCTRL_WMASK;
   end

   assign fflag_clr = wr_to(wpf_pkg::IDX_STATUS, wr_go, aw_idx_r, wstrb0_r)
                      && wdata_r[wpf_pkg::ST_FFLAG_BIT]; // RL24

   assign patm = ctrl_r[wpf_pkg::CTRL_PAT_BIT];
   assign comw = ctrl_r[wpf_pkg::CTRL_COMW_BIT];

   // Buffers load from software and move to the live registers on UPDATE
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dtlsbuf_r <= wpf_pkg::RST_BYTE;
         lsv_r     <= 1'b0;
      end else if (wr_to(wpf_pkg::IDX_DTLSBUF, wr_go, aw_idx_r, wstrb0_r)) begin
         dtlsbuf_r <= wdata_r;
         lsv_r     <= 1'b1;
      end else if (tc_update) begin
         lsv_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dthsbuf_r <= wpf_pkg::RST_BYTE;
         hsv_r     <= 1'b0;
      end else if (wr_to(wpf_pkg::IDX_DTHSBUF, wr_go, aw_idx_r, wstrb0_r)) begin
         dthsbuf_r <= wdata_r;
         hsv_r     <= 1'b1;
      end else if (tc_update && !(patm && fault_active)) begin
         hsv_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) dtls_r <= wpf_pkg::RST_BYTE;
      else if (wr_to(wpf_pkg::IDX_DTLS, wr_go, aw_idx_r, wstrb0_r)) dtls_r <= wdata_r;
      else if (tc_update && lsv_r) dtls_r <= dtlsbuf_r; // RL1 RL3
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) dths_r <= wpf_pkg::RST_BYTE;
      else if (wr_to(wpf_pkg::IDX_DTHS, wr_go, aw_idx_r, wstrb0_r)) dths_r <= wdata_r;
      else if (tc_update && hsv_r && !patm) dths_r <= dthsbuf_r;
   end

   // In pattern mode the high side buffer carries the override enables,
   // so software and pattern updates alike are frozen during a fault
   always_ff @(posedge aclk) begin
      if (!aresetn) ovren_r <= wpf_pkg::RST_BYTE;
      else if (!fault_active) begin // RL13
         if (wr_to(wpf_pkg::IDX_OVREN, wr_go, aw_idx_r, wstrb0_r) && !ext_lock) // RL15
            ovren_r <= wdata_r;
         else if (tc_update && hsv_r && patm) ovren_r <= dthsbuf_r; // RL3
      end
   end

   wpf_fault_unit u_fault (
      .aclk          (aclk),
      .aresetn       (aresetn),
      .fault_evt     (fault_evt),
      .evt_mask      (fdmask_r),
      .fault_act     (fdctrl_r[1:0]),
      .restore_cbc   (fdctrl_r[wpf_pkg::FD_MODE_BIT]), // RL23
      .dbg_fault_dis (fdctrl_r[wpf_pkg::FD_DBD_BIT]),
      .dbg_break     (dbg_break),
      .tc_update     (tc_update),
      .fflag_clr     (fflag_clr),
      .fault_cond    (fault_cond),
      .fault_active  (fault_active),
      .fflag         (fflag)
   );

   assign chan_mask  = wpf_pkg::chan_pins(ctrl_r[3:0]);
   assign act_clr    = (fdctrl_r[1:0] == wpf_pkg::ACT_CLEARDIR);
   // Unregistered so the port sees the clear in the event's own cycle
   assign dir_clear  = (act_clr && (fault_cond || fault_active)) ? chan_mask : 8'h00; // RL6 RL8
   assign tc_err_set = fault_cond; // RL7
   assign fault_state = fault_active;

   // Direction restore is a one-cycle pulse on leaving the fault
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fault_prev_r  <= 1'b0;
         dir_restore_r <= 8'h00;
      end else begin
         fault_prev_r  <= fault_active;
         dir_restore_r <= (fault_prev_r && !fault_active && act_clr) ? chan_mask : 8'h00; // RL12
      end
   end
   assign dir_restore = dir_restore_r;

   // Channel sources; dead-time counting itself sits outside this block
   assign wave = comw ? {4{tc_waveform[0]}} : tc_waveform; // RL19

   always_comb begin
      pin_out_nxt = 8'h00;
      pin_ovr_nxt = 8'h00;
      if (patm) begin
         for (int i = 0; i < 8; i++)
            pin_out_nxt[i] = ovren_r[i] ? tc_waveform[0] : dtls_r[i]; // RL1 RL2 RL18
         pin_ovr_nxt = 8'hff;
      end else begin
         for (int c = 0; c < 4; c++) begin
            pin_out_nxt[2*c]   = ctrl_r[c] & wave[c]; // RL20
            pin_out_nxt[2*c+1] = ctrl_r[c] & ~wave[c];
         end
         pin_ovr_nxt = chan_mask & ovren_r; // RL20
      end
      if (fault_active && act_clr) pin_out_nxt = 8'h00;
   end

   // Pins follow the pattern only where software made them outputs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_out_r <= 8'h00;
         pin_ovr_r <= 8'h00;
      end else begin
         pin_out_r <= pin_out_nxt; // RL4
         pin_ovr_r <= pin_ovr_nxt;
      end
   end
   assign pin_out    = pin_out_r;
   assign pin_ovr_en = pin_ovr_r;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_event_clears_dir: assert property ((|(fault_evt & fdmask_r)) && act_clr
      |-> dir_clear == chan_mask) // RL6
      else $error("direction not cleared on fault event");
   a_dir_clear_held: assert property (fault_active && act_clr |-> ##[0:2] dir_clear == chan_mask) // RL8
      else $error("fault action late");
   a_restore_dirs: assert property (fault_active && act_clr ##1 !fault_active
      |=> dir_restore == $past(chan_mask)) // RL12
      else $error("directions not restored");
   a_oov_blocked: assert property (fault_active |=> $stable(ovren_r)) // RL13
      else $error("override enable changed in fault");
   a_lock_ctrl: assert property (ext_lock |=> $stable(ctrl_r) && $stable(fdmask_r)) // RL15
      else $error("locked register changed");
   a_pattern_upd: assert property (tc_update && lsv_r && !wr_to(wpf_pkg::IDX_DTLS, wr_go,
      aw_idx_r, wstrb0_r) |=> dtls_r == $past(dtlsbuf_r)) // RL3
      else $error("pattern buffer not applied");
   a_flag_clear: assert property (fflag && fflag_clr && !fault_cond |=> !fflag) // RL24
      else $error("fault flag not cleared");
   a_pattern_pins: assert property (patm && !fault_active ##1 patm
      |-> pin_ovr_en == 8'hff) // RL18
      else $error("pattern mode not overriding pins");
endmodule
`default_nettype wire
